// ===== logic/nci_defines.svh
// Offsets, field positions, reset values and timing counts of the issuer
`ifndef NCI_DEFINES_SVH
`define NCI_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define NCI_OFF_CMD_BYTES 8'h00
`define NCI_OFF_RESP_LIMIT 8'h04
`define NCI_OFF_DEST_NET 8'h08
`define NCI_OFF_DEST_NODE_UNIT 8'h0c
`define NCI_OFF_RETRY_RESP 8'h10
`define NCI_OFF_RESP_TIMEOUT 8'h14
`define NCI_OFF_CMD_CODE 8'h18
`define NCI_OFF_XFER_WORDS 8'h1c
`define NCI_OFF_AREA_ROOM 8'h20
`define NCI_OFF_CONTROL 8'h24
`define NCI_OFF_STATUS 8'h28

// ==========================================================
// Field positions
`define NCI_CTL_INVOKE 0
`define NCI_CTL_RATE_LSB 1
`define NCI_ST_ENABLED 16
`define NCI_ST_NET_ERROR 17
`define NCI_ST_GEN_ERROR 18
`define NCI_ST_BUSY 19
`define NCI_ST_RETRY_LSB 24

// ==========================================================
// Reset values and limits
`define NCI_CW_RESET 16'h0000
`define NCI_RATE_RESET 2'h0
`define NCI_MAX_BYTES 16'h07c6
`define NCI_MAX_NET 8'h7f
`define NCI_NODE_MIN 8'h01
`define NCI_NODE_MAX 8'h20
`define NCI_NODE_BCAST 8'hff
`define NCI_MAX_RETRY 8'h0f
`define NCI_RESP_WANTED 8'h00
`define NCI_RESP_NONE 8'h80
`define NCI_CODE_AREA_WRITE 16'h0102
`define NCI_CODE_AREA_READ 16'h0101
`define NCI_MAX_BLOCK_WORDS 16'h03de
`define NCI_RESP_HDR_BYTES 16'h0004

// ==========================================================
// Timing: 0.1 s unit, 25 ns clock
`define NCI_TICK_NS 100000000
`define NCI_CLK_NS 25
`define NCI_DEF_TICKS_2M 16'h0014
`define NCI_DEF_TICKS_1M 16'h0028
`define NCI_DEF_TICKS_500K 16'h0050

// ==========================================================
// Completion codes raised locally (values arbitrary)
`define NCI_CC_OK 16'h0000
`define NCI_CC_TIMEOUT 16'h00f1
`define NCI_CC_PARAM 16'h00f2
`define NCI_CC_OVERSIZE 16'h00f3
`define NCI_CC_BOUNDARY 16'h00f4
`define NCI_CC_NOLINK 16'h00f5
`define NCI_CC_ECHO 16'h00f6

`endif

// ===== logic/nci_pkg.sv
// Types shared by the network command issuer
package nci_pkg;

    typedef enum logic [1:0] {
        NCI_IDLE,
        NCI_PEND,
        NCI_SEND,
        NCI_WAIT
    } nci_state_e;

    typedef struct packed {
        logic [5:0][15:0] cw;
        logic [15:0] cmd_code;
        logic [15:0] xfer_words;
        logic [15:0] area_room;
        logic [1:0] rate;
        nci_state_e state;
        logic enabled;
        logic net_error;
        logic gen_error;
        logic [15:0] ccode;
        logic [7:0] retries_left;
        logic [31:0] tick_cnt;
        logic [15:0] elapsed;
        logic link_p1;
        logic link_p2;
        logic tx_valid;
        logic tx_bcast;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } nci_regs_s;

endpackage

// ===== logic/nci_issuer.sv
// Network command issuer: APB control words, link request and response
// ==========================================================
// How it works
// - Command byte count limited to 07C6
// - Response byte limit limited to 07C6
// - Network low byte 00..7F, high 00
// - Unit low byte; node 01..20 or FF
// - Retry count field 00 to 0F
// - Response setting 00 wanted, 80 none
// - Timeout in 0.1 s; 0000 rate default
// - Reissue on timeout until retries exhausted
// - Broadcast: send to all, no retries
// - Oversized response raises network error
// - Invoked while disabled: general error only
// - Invoke clears enabled and network error flags, code 00, issues
// - Enabled flag rising marks completion
// - Codes 0102/0101 act as block transfers
// - Read response: echo, code, data
// - Block receive beyond area is error
// - Block transfer over 990 words errors
// - No link unit on block transfer errors
// - Transmission processed at scan end
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "nci_defines.svh"

module nci_issuer #(
    parameter int unsigned TICK_CYCLES = `NCI_TICK_NS / `NCI_CLK_NS
) (
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic PREADY_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic PSLVERR_OUT,
    input wire logic SCAN_END_IN,
    input wire logic LINK_PRESENT_IN,
    output logic LINK_TX_VALID_OUT,
    input wire logic LINK_TX_READY_IN,
    output logic [15:0] LINK_TX_CODE_OUT,
    output logic [15:0] LINK_TX_BYTES_OUT,
    output logic [7:0] LINK_TX_NET_OUT,
    output logic [7:0] LINK_TX_NODE_OUT,
    output logic [7:0] LINK_TX_UNIT_OUT,
    output logic LINK_TX_BROADCAST_OUT,
    input wire logic LINK_RESP_VALID_IN,
    input wire logic [15:0] LINK_RESP_BYTES_IN,
    input wire logic [15:0] LINK_RESP_ECHO_IN,
    input wire logic [15:0] LINK_RESP_CODE_IN,
    output logic NETWORK_OP_ENABLED_FLAG_OUT,
    output logic NETWORK_OP_ERROR_FLAG_OUT,
    output logic GENERAL_ERROR_FLAG_OUT,
    output logic [15:0] COMPLETION_CODE_OUT
);
    import nci_pkg::*;

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    nci_regs_s r;
    nci_regs_s next_r;

    // ==========================================================
    // Decoded control words
    logic [15:0] cmd_bytes;
    logic [15:0] resp_limit;
    logic [7:0] net_lo;
    logic [7:0] net_hi;
    logic [7:0] unit;
    logic [7:0] node;
    logic [7:0] retry_cnt;
    logic [7:0] resp_set;
    logic [15:0] timeout_ticks;
    logic is_block;
    logic is_read;
    logic bcast;
    logic params_bad;
    logic unit_ok;

    always_comb begin
        cmd_bytes = r.cw[0];
        resp_limit = r.cw[1];
        net_lo = r.cw[2][7:0];
        net_hi = r.cw[2][15:8];
        unit = r.cw[3][7:0];
        node = r.cw[3][15:8];
        retry_cnt = r.cw[4][7:0];
        resp_set = r.cw[4][15:8];
        is_read = (r.cmd_code == `NCI_CODE_AREA_READ);
        is_block = is_read || (r.cmd_code == `NCI_CODE_AREA_WRITE);
        bcast = (node == `NCI_NODE_BCAST);
        unit_ok = (unit == 8'h00) || (unit == 8'h01) ||
                  (unit[7:4] == 4'h1) || (unit == 8'he1) ||
                  (unit == 8'hfe);
        params_bad = (cmd_bytes > `NCI_MAX_BYTES) ||
                     (resp_limit > `NCI_MAX_BYTES) ||
                     (net_lo > `NCI_MAX_NET) || (net_hi != 8'h00) ||
                     !unit_ok ||
                     (!bcast && ((node < `NCI_NODE_MIN) ||
                                 (node > `NCI_NODE_MAX))) ||
                     (retry_cnt > `NCI_MAX_RETRY) ||
                     ((resp_set != `NCI_RESP_WANTED) &&
                      (resp_set != `NCI_RESP_NONE));
        // Zero selects a default tied to the link rate
        if (r.cw[5] != 16'h0000) begin
            timeout_ticks = r.cw[5];
        end else begin
            case (r.rate)
                2'h1: timeout_ticks = `NCI_DEF_TICKS_1M;
                2'h2: timeout_ticks = `NCI_DEF_TICKS_500K;
                default: timeout_ticks = `NCI_DEF_TICKS_2M;
            endcase
        end
    end

    // ==========================================================
    // Bus decode
    logic bus_access;
    logic bus_wr;
    logic addr_ok;
    logic [31:0] rd_word;
    logic invoke;
    logic gen_err_clr;
    logic [15:0] resp_data_words;

    always_comb begin
        bus_access = PSEL_IN && PENABLE_IN && !r.pready;
        bus_wr = bus_access && PWRITE_IN;
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (PADDR_IN)
            `NCI_OFF_CMD_BYTES: rd_word = {16'h0000, r.cw[0]};
            `NCI_OFF_RESP_LIMIT: rd_word = {16'h0000, r.cw[1]};
            `NCI_OFF_DEST_NET: rd_word = {16'h0000, r.cw[2]};
            `NCI_OFF_DEST_NODE_UNIT: rd_word = {16'h0000, r.cw[3]};
            `NCI_OFF_RETRY_RESP: rd_word = {16'h0000, r.cw[4]};
            `NCI_OFF_RESP_TIMEOUT: rd_word = {16'h0000, r.cw[5]};
            `NCI_OFF_CMD_CODE: rd_word = {16'h0000, r.cmd_code};
            `NCI_OFF_XFER_WORDS: rd_word = {16'h0000, r.xfer_words};
            `NCI_OFF_AREA_ROOM: rd_word = {16'h0000, r.area_room};
            `NCI_OFF_CONTROL: begin
                rd_word[`NCI_CTL_RATE_LSB +: 2] = r.rate;
            end
            `NCI_OFF_STATUS: begin
                rd_word[15:0] = r.ccode;
                rd_word[`NCI_ST_ENABLED] = r.enabled;
                rd_word[`NCI_ST_NET_ERROR] = r.net_error;
                rd_word[`NCI_ST_GEN_ERROR] = r.gen_error;
                rd_word[`NCI_ST_BUSY] = (r.state != NCI_IDLE);
                rd_word[`NCI_ST_RETRY_LSB +: 8] = r.retries_left;
            end
            default: addr_ok = 1'b0;
        endcase
        invoke = bus_wr && (PADDR_IN == `NCI_OFF_CONTROL) &&
                 PWDATA_IN[`NCI_CTL_INVOKE];
        gen_err_clr = bus_wr && (PADDR_IN == `NCI_OFF_STATUS) &&
                      PWDATA_IN[`NCI_ST_GEN_ERROR];
        // Data words after the echo and completion code
        if (LINK_RESP_BYTES_IN > `NCI_RESP_HDR_BYTES) begin
            resp_data_words = 16'((LINK_RESP_BYTES_IN -
                                   `NCI_RESP_HDR_BYTES) >> 1);
        end else begin
            resp_data_words = 16'h0000;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.pready = bus_access;
        next_r.pslverr = bus_access && !addr_ok;
        next_r.prdata = (bus_access && !PWRITE_IN) ? rd_word : 32'h0000_0000;
        next_r.link_p1 = LINK_PRESENT_IN;
        next_r.link_p2 = r.link_p1;
        next_r.tx_bcast = bcast;

        if (bus_wr) begin
            case (PADDR_IN)
                `NCI_OFF_CMD_BYTES: next_r.cw[0] = PWDATA_IN[15:0];
                `NCI_OFF_RESP_LIMIT: next_r.cw[1] = PWDATA_IN[15:0];
                `NCI_OFF_DEST_NET: next_r.cw[2] = PWDATA_IN[15:0];
                `NCI_OFF_DEST_NODE_UNIT: next_r.cw[3] = PWDATA_IN[15:0];
                `NCI_OFF_RETRY_RESP: next_r.cw[4] = PWDATA_IN[15:0];
                `NCI_OFF_RESP_TIMEOUT: next_r.cw[5] = PWDATA_IN[15:0];
                `NCI_OFF_CMD_CODE: next_r.cmd_code = PWDATA_IN[15:0];
                `NCI_OFF_XFER_WORDS: next_r.xfer_words = PWDATA_IN[15:0];
                `NCI_OFF_AREA_ROOM: next_r.area_room = PWDATA_IN[15:0];
                `NCI_OFF_CONTROL: begin
                    next_r.rate = PWDATA_IN[`NCI_CTL_RATE_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // Write-one clears; a new error in the same cycle wins below
        if (gen_err_clr) begin
            next_r.gen_error = 1'b0;
        end

        // Timeout base: one enable pulse per 0.1 s
        if (r.state == NCI_WAIT) begin
            if (r.tick_cnt == TICK_LAST) begin
                next_r.tick_cnt = 32'h0000_0000;
                next_r.elapsed = r.elapsed + 16'h0001;
            end else begin
                next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
            end
        end

        case (r.state)
            NCI_IDLE: begin
                if (invoke) begin
                    // Callers gate on the flag; a stray call only flags
                    if (!r.enabled) begin
                        next_r.gen_error = 1'b1;
                    end else begin
                        next_r.enabled = 1'b0;
                        next_r.net_error = 1'b0;
                        next_r.ccode = `NCI_CC_OK;
                        next_r.state = NCI_PEND;
                    end
                end
            end
            NCI_PEND: begin
                // Words are trusted unchanged from here on
                if (SCAN_END_IN) begin
                    next_r.retries_left = retry_cnt;
                    if (is_block && !r.link_p2) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_NOLINK;
                        next_r.enabled = 1'b1;
                        next_r.state = NCI_IDLE;
                    end else if (is_block &&
                                 r.xfer_words > `NCI_MAX_BLOCK_WORDS) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_PARAM;
                        next_r.enabled = 1'b1;
                        next_r.state = NCI_IDLE;
                    end else if (params_bad) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_PARAM;
                        next_r.enabled = 1'b1;
                        next_r.state = NCI_IDLE;
                    end else begin
                        next_r.tx_valid = 1'b1;
                        next_r.state = NCI_SEND;
                    end
                end
            end
            NCI_SEND: begin
                if (LINK_TX_READY_IN) begin
                    next_r.tx_valid = 1'b0;
                    next_r.tick_cnt = 32'h0000_0000;
                    next_r.elapsed = 16'h0000;
                    if (bcast || resp_set == `NCI_RESP_NONE) begin
                        next_r.enabled = 1'b1;
                        next_r.state = NCI_IDLE;
                    end else begin
                        next_r.state = NCI_WAIT;
                    end
                end
            end
            NCI_WAIT: begin
                if (LINK_RESP_VALID_IN) begin
                    next_r.enabled = 1'b1;
                    next_r.state = NCI_IDLE;
                    next_r.ccode = LINK_RESP_CODE_IN;
                    if (LINK_RESP_BYTES_IN > resp_limit) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_OVERSIZE;
                    end else if (LINK_RESP_ECHO_IN != r.cmd_code) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_ECHO;
                    end else if (is_read &&
                                 resp_data_words > r.area_room) begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_BOUNDARY;
                    end else if (LINK_RESP_CODE_IN != `NCI_CC_OK) begin
                        next_r.net_error = 1'b1;
                    end
                end else if (r.elapsed >= timeout_ticks) begin
                    if (r.retries_left != 8'h00) begin
                        next_r.retries_left = r.retries_left - 8'h01;
                        next_r.tx_valid = 1'b1;
                        next_r.state = NCI_SEND;
                    end else begin
                        next_r.net_error = 1'b1;
                        next_r.ccode = `NCI_CC_TIMEOUT;
                        next_r.enabled = 1'b1;
                        next_r.state = NCI_IDLE;
                    end
                end
            end
            default: begin
                next_r.state = NCI_IDLE;
            end
        endcase

        // A refused call sets the flag even while a clear is written
        if (invoke && !r.enabled) begin
            next_r.gen_error = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            r <= '0;
            r.cw <= {6{`NCI_CW_RESET}};
            r.rate <= `NCI_RATE_RESET;
            r.state <= NCI_IDLE;
            r.enabled <= 1'b1;
            r.ccode <= `NCI_CC_OK;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs, all from flops
    assign PREADY_OUT = r.pready;
    assign PRDATA_OUT = r.prdata;
    assign PSLVERR_OUT = r.pslverr;
    assign LINK_TX_VALID_OUT = r.tx_valid;
    assign LINK_TX_CODE_OUT = r.cmd_code;
    assign LINK_TX_BYTES_OUT = r.cw[0];
    assign LINK_TX_NET_OUT = r.cw[2][7:0];
    assign LINK_TX_NODE_OUT = r.cw[3][15:8];
    assign LINK_TX_UNIT_OUT = r.cw[3][7:0];
    assign LINK_TX_BROADCAST_OUT = r.tx_bcast;
    assign NETWORK_OP_ENABLED_FLAG_OUT = r.enabled;
    assign NETWORK_OP_ERROR_FLAG_OUT = r.net_error;
    assign GENERAL_ERROR_FLAG_OUT = r.gen_error;
    assign COMPLETION_CODE_OUT = r.ccode;

endmodule

// ===== verification/nci_issuer_chk.sv
// Port-level assertions for the network command issuer
`timescale 1ns/1ps
`include "nci_defines.svh"

module nci_issuer_chk #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic LINK_TX_VALID_OUT,
    input wire logic LINK_TX_READY_IN,
    input wire logic [7:0] LINK_TX_NODE_OUT,
    input wire logic LINK_TX_BROADCAST_OUT,
    input wire logic LINK_RESP_VALID_IN,
    input wire logic NETWORK_OP_ENABLED_FLAG_OUT,
    input wire logic NETWORK_OP_ERROR_FLAG_OUT,
    input wire logic GENERAL_ERROR_FLAG_OUT,
    input wire logic [15:0] COMPLETION_CODE_OUT
);
    wire logic en = NETWORK_OP_ENABLED_FLAG_OUT;
    wire logic txv = LINK_TX_VALID_OUT;
    wire logic acc = LINK_TX_VALID_OUT && LINK_TX_READY_IN;
    wire logic acs = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    wire logic inv = acs && PWRITE_IN && PADDR_IN == `NCI_OFF_CONTROL
        && PWDATA_IN[0];
    logic sent;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    // Accepted request still waiting for its answer
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN || en) begin
            sent <= 1'b0;
        end else if (acc) begin
            sent <= 1'b1;
        end
    end

    // ==========
    // Assertions
    a_apb_one_wait: assert property (acs |=> PREADY_OUT)
        else $error("apb answer not one cycle after access");
    a_slverr_qual: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("slave error without ready");
    a_tx_hold_req: assert property (txv && !LINK_TX_READY_IN
        |=> txv && $stable(LINK_TX_NODE_OUT))
        else $error("link request dropped or changed before ready");
    a_tx_release: assert property (acc |=> !txv)
        else $error("link request held after ready");
    a_busy_flag_low: assert property (txv |-> !en)
        else $error("enabled flag high while request pending");
    a_bcast_no_wait: assert property (acc && LINK_TX_BROADCAST_OUT
        |-> ##[1:2] en) else $error("broadcast waited for a response");
    a_invoke_clears: assert property (inv && en |=> !en
        && !NETWORK_OP_ERROR_FLAG_OUT && COMPLETION_CODE_OUT == 16'h0000)
        else $error("invoke did not clear flags and code");
    a_gen_err_set: assert property (inv && !en
        |=> GENERAL_ERROR_FLAG_OUT) else $error("disabled invoke no error");
    a_resp_done: assert property (LINK_RESP_VALID_IN && sent
        && !txv && !en |=> en) else $error("response left op open");

    c_bcast: cover property (acc && LINK_TX_BROADCAST_OUT);
    c_resp: cover property (LINK_RESP_VALID_IN && sent);
    c_slverr: cover property (PSLVERR_OUT);
    c_gen_err: cover property (inv && !en);
endmodule

bind nci_issuer nci_issuer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .MCLK_IN, .RESET_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
    .PWDATA_IN, .PREADY_OUT, .PSLVERR_OUT, .LINK_TX_VALID_OUT,
    .LINK_TX_READY_IN, .LINK_TX_NODE_OUT, .LINK_TX_BROADCAST_OUT,
    .LINK_RESP_VALID_IN, .NETWORK_OP_ENABLED_FLAG_OUT,
    .NETWORK_OP_ERROR_FLAG_OUT, .GENERAL_ERROR_FLAG_OUT,
    .COMPLETION_CODE_OUT
);

// ===== verification/nci_link_model.sv
// Behavioural remote node answering the issuer's link requests
`timescale 1ns/1ps

module nci_link_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tx_valid,
    input wire logic [15:0] tx_code,
    input wire logic tx_bcast,
    input wire logic [7:0] drop_n,
    input wire logic [15:0] rbytes,
    output logic tx_ready,
    output logic resp_valid,
    output logic [15:0] resp_bytes,
    output logic [15:0] resp_echo,
    output logic [15:0] resp_code,
    output logic [7:0] n_sent
);
    logic [1:0] wcnt;
    logic [2:0] rcnt;
    logic [15:0] echo;

    always_ff @(posedge clk) begin
        tx_ready <= 1'b0;
        resp_valid <= 1'b0;
        // Answer lines toggle outside the answer cycle
        resp_bytes <= ~resp_bytes;
        resp_echo <= ~resp_echo;
        resp_code <= ~resp_code;
        if (!rst_n) begin
            wcnt <= 2'h0;
            rcnt <= 3'h0;
            n_sent <= 8'h00;
        end else begin
            // Odd sends accepted slowly, even ones at once
            if (tx_valid && !tx_ready) begin
                if (wcnt == {2{n_sent[0]}}) begin
                    tx_ready <= 1'b1;
                    wcnt <= 2'h0;
                    n_sent <= n_sent + 8'h01;
                    echo <= tx_code;
                    if (!tx_bcast && n_sent >= drop_n) begin
                        rcnt <= 3'h6;
                    end
                end else begin
                    wcnt <= wcnt + 2'h1;
                end
            end
            if (rcnt != 3'h0) begin
                rcnt <= rcnt - 3'h1;
            end
            if (rcnt == 3'h1) begin
                resp_valid <= 1'b1;
                resp_bytes <= rbytes;
                resp_echo <= echo;
                resp_code <= 16'h0000;
            end
        end
    end
endmodule

// ===== verification/nci_issuer_tb.sv
// Self-checking bench for the network command issuer
`timescale 1ns/1ps
`include "nci_defines.svh"

module nci_issuer_tb;
    logic clk, rst_n, psel, pen, pwr, scan, lp, rd_err, ok;
    logic pready, pslverr, txv, txr, txb, rv, en, nerr, gerr;
    logic [7:0] paddr, net, node, unit, m_drop, n_sent, s0;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] code, bytes, rb, re, rc, cc, m_bytes;
    logic [5:0][15:0] g;
    int n_mismatch, n_tests, k;

    nci_issuer #(.TICK_CYCLES(4)) uut (
        .MCLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
        .PSLVERR_OUT(pslverr), .SCAN_END_IN(scan), .LINK_PRESENT_IN(lp),
        .LINK_TX_VALID_OUT(txv), .LINK_TX_READY_IN(txr),
        .LINK_TX_CODE_OUT(code), .LINK_TX_BYTES_OUT(bytes),
        .LINK_TX_NET_OUT(net), .LINK_TX_NODE_OUT(node),
        .LINK_TX_UNIT_OUT(unit), .LINK_TX_BROADCAST_OUT(txb),
        .LINK_RESP_VALID_IN(rv), .LINK_RESP_BYTES_IN(rb),
        .LINK_RESP_ECHO_IN(re), .LINK_RESP_CODE_IN(rc),
        .NETWORK_OP_ENABLED_FLAG_OUT(en), .NETWORK_OP_ERROR_FLAG_OUT(nerr),
        .GENERAL_ERROR_FLAG_OUT(gerr), .COMPLETION_CODE_OUT(cc)
    );
    nci_link_model link (
        .clk(clk), .rst_n(rst_n), .tx_valid(txv), .tx_code(code),
        .tx_bcast(txb), .drop_n(m_drop), .rbytes(m_bytes), .tx_ready(txr),
        .resp_valid(rv), .resp_bytes(rb), .resp_echo(re), .resp_code(rc),
        .n_sent(n_sent)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask
    task automatic set_cw(input logic [5:0][15:0] w);
        for (int i = 0; i < 6; i++) wr(8'(4 * i), {16'h0, w[i]});
    endtask
    task automatic inv(input logic [31:0] ctl);
        s0 = n_sent;
        wr(`NCI_OFF_CONTROL, ctl);
        apb(`NCI_OFF_STATUS, 1'b0, 32'h0, q);
        chk(q & 32'h0003ffff, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(txv), 32'h0);
        scan <= 1'b1;
        @(posedge clk);
        scan <= 1'b0;
    endtask
    task automatic fin(input logic e, input logic [15:0] c, input int n);
        k = 0;
        while (en !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk(32'(en), 32'h1);
        chk(32'(nerr), 32'(e));
        chk(32'(cc), 32'(c));
        chk(32'(n_sent - s0), n);
    endtask
    task automatic op(input logic [31:0] ctl, input logic e,
                      input logic [15:0] c, input int n);
        inv(ctl);
        fin(e, c, n);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; this is ample
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    // ==========
    // Sequence
    initial begin
        int bi [9];
        logic [15:0] bv [9];
        logic [5:0][15:0] b;
        {rst_n, psel, pen, pwr, scan, paddr, pwdata} = '0;
        lp = 1'b1;
        m_drop = 8'h00;
        m_bytes = 16'h0018;
        bi = '{0, 1, 2, 2, 3, 3, 3, 4, 4};
        bv = '{16'h07c7, 16'h07c7, 16'h0080, 16'h0100, 16'h0000, 16'h2100,
               16'h0305, 16'h0010, 16'h4000};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i <= 10; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0, q);
            chk(q, i == 10 ? 32'h00010000 : 32'h0);
        end
        apb(8'h3c, 1'b0, 32'h0, q);
        chk({q[30:0], rd_err}, 32'h1);
        b = {16'hffff, 16'h800f, 16'hff20, 16'h007f, 16'h07c6, 16'h07c6};
        set_cw(b);
        for (int i = 0; i < 6; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0, q);
            chk(q, {16'h0, b[i]});
        end
        g = {16'h0003, 16'h0003, 16'h0300, 16'h0000, 16'h0018, 16'h0008};
        set_cw(g);
        wr(`NCI_OFF_CMD_CODE, 32'h0101);
        wr(`NCI_OFF_XFER_WORDS, 32'h000a);
        wr(`NCI_OFF_AREA_ROOM, 32'h000a);
        op(32'h1, 1'b0, `NCI_CC_OK, 1);
        chk({node, unit, bytes}, 32'h03000008);
        chk(32'(net), 32'h0);
        m_bytes <= 16'h001a;
        op(32'h1, 1'b1, `NCI_CC_OVERSIZE, 1);
        m_bytes <= 16'h0018;
        wr(`NCI_OFF_AREA_ROOM, 32'h0009);
        op(32'h1, 1'b1, `NCI_CC_BOUNDARY, 1);
        wr(`NCI_OFF_AREA_ROOM, 32'h000a);
        m_drop <= n_sent + 8'h01;
        op(32'h1, 1'b0, `NCI_CC_OK, 2);
        m_drop <= 8'hff;
        set_cw({16'h0001, 16'h0002, g[3:0]});
        op(32'h1, 1'b1, `NCI_CC_TIMEOUT, 3);
        set_cw({32'h0, g[3:0]});
        for (int r = 0; r < 3; r++) begin
            op({29'h0, 2'(r), 1'b1}, 1'b1, `NCI_CC_TIMEOUT, 1);
            ok = k >= (80 << r) && k <= (80 << r) + 20;
            chk(32'(ok), 32'h1);
        end
        set_cw({g[5:4], 16'hff00, g[2:0]});
        op(32'h1, 1'b0, `NCI_CC_OK, 1);
        chk(32'(txb), 32'h1);
        set_cw({g[5], 16'h8003, g[3:0]});
        op(32'h1, 1'b0, `NCI_CC_OK, 1);
        m_drop <= 8'h00;
        for (int i = 0; i < 9; i++) begin
            b = g;
            b[bi[i]] = bv[i];
            set_cw(b);
            op(32'h1, 1'b1, `NCI_CC_PARAM, 0);
        end
        set_cw(g);
        wr(`NCI_OFF_XFER_WORDS, 32'h03df);
        op(32'h1, 1'b1, `NCI_CC_PARAM, 0);
        wr(`NCI_OFF_XFER_WORDS, 32'h000a);
        wr(`NCI_OFF_CMD_CODE, 32'h0102);
        lp <= 1'b0;
        repeat (3) @(posedge clk);
        op(32'h1, 1'b1, `NCI_CC_NOLINK, 0);
        lp <= 1'b1;
        repeat (3) @(posedge clk);
        inv(32'h1);
        wr(`NCI_OFF_CONTROL, 32'h1);
        chk(32'(gerr), 32'h1);
        fin(1'b0, `NCI_CC_OK, 1);
        wr(`NCI_OFF_STATUS, 32'h00040000);
        chk(32'(gerr), 32'h0);
        print_verdict();
    end
endmodule
